// ---- hw/rcp_edge_det.sv ----
// Purpose: Edge pulses of the rail control pins
// Assumes: Pins synchronous to pclk
// Notes:   Previous level resets low, so a pin high at release gives a rise
`timescale 1ns/10ps
module rcp_edge_det (
   // Clock and reset
   input  wire logic                        pclk,
   input  wire logic                        presetn,
   // Levels and pulses
   input  wire logic [rcp_pkg::CTL_CNT-1:0] lvl,
   output logic      [rcp_pkg::CTL_CNT-1:0] rise,
   output logic      [rcp_pkg::CTL_CNT-1:0] fall
);
   rcp_pkg::rcp_edge_st_t st_ff;
   rcp_pkg::rcp_edge_st_t nxt_st;

   always_comb begin
      nxt_st      = st_ff;
      nxt_st.prev = lvl;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_ff <= rcp_pkg::EDGE_RST;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign rise = lvl & ~st_ff.prev;
   assign fall = ~lvl & st_ff.prev;
endmodule : rcp_edge_det

// ---- hw/rcp_gen_out.sv ----
// Purpose: One general-purpose output pin stage
// Assumes: Power-good inputs synchronous to pclk
// Notes:   Output enable is low while the pin is driven
`timescale 1ns/10ps
module rcp_gen_out #(
   parameter bit OD_ONLY = 1'b0
) (
   // Clock and reset
   input  wire logic                        pclk,
   input  wire logic                        presetn,
   // Configuration and status
   input  wire rcp_pkg::rcp_gpo_cfg_t       cfg,
   input  wire logic [rcp_pkg::REG_CNT-1:0] pg,
   // Pin
   output logic                             pin_o,
   output logic                             pin_oe_n
);
   rcp_pkg::rcp_gout_st_t st_ff;
   rcp_pkg::rcp_gout_st_t nxt_st;
   logic                  drive_pp;

   always_comb begin
      nxt_st = st_ff;
      if (cfg.src_reg) begin
         nxt_st.level = cfg.val;
      end else begin
         nxt_st.level = (cfg.sel != '0) && ((pg & cfg.sel) == cfg.sel);
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_ff <= rcp_pkg::GOUT_RST;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign drive_pp = cfg.push_pull && !OD_ONLY;
   assign pin_o    = drive_pp ? st_ff.level : 1'b0;
   assign pin_oe_n = drive_pp ? 1'b0 : st_ff.level;
endmodule : rcp_gen_out

// ---- hw/rcp_pkg.sv ----
// Purpose: Shared constants and types of the rail control pin logic
// Assumes: 32-bit APB, one aligned word per register
// Notes:   Regulator count is fixed here because the state structs depend on it
package rcp_pkg;
   //--------------------------------------------------
   // Sizes
   //--------------------------------------------------
   localparam int CTL_CNT    = 6;
   localparam int REG_CNT    = 8;
   localparam int GPO_CNT    = 4;
   localparam int GPO_PP_CNT = 3;
   localparam int EV_W       = 7;
   localparam int IDX_C      = 2;
   localparam int IDX_F      = 5;
   //--------------------------------------------------
   // Register byte addresses
   //--------------------------------------------------
   localparam logic [7:0] A_GRP_BASE  = 8'h00;
   localparam logic [7:0] A_SLP_MODE  = 8'h18;
   localparam logic [7:0] A_SLP_GRP_C = 8'h1C;
   localparam logic [7:0] A_SLP_GRP_F = 8'h20;
   localparam logic [7:0] A_GPO_BASE  = 8'h24;
   localparam logic [7:0] A_RAIL_ST   = 8'h34;
   localparam logic [7:0] A_SLP_ST    = 8'h38;
   localparam logic [7:0] A_INT_ST    = 8'h3C;
   localparam logic [7:0] A_INT_MSK   = 8'h40;
   localparam logic [7:0] A_STRIDE    = 8'h04;
   //--------------------------------------------------
   // Field positions
   //--------------------------------------------------
   localparam int F_SLP_C   = 0;
   localparam int F_SLP_F   = 1;
   localparam int F_GPO_SRC = 16;
   localparam int F_GPO_VAL = 17;
   localparam int F_GPO_PP  = 18;
   localparam int F_EV_PG   = 6;
   //--------------------------------------------------
   // Types
   //--------------------------------------------------
   typedef struct packed {
      logic               src_reg;
      logic               val;
      logic               push_pull;
      logic [REG_CNT-1:0] sel;
   } rcp_gpo_cfg_t;

   typedef struct packed {
      logic [CTL_CNT-1:0][REG_CNT-1:0] grp;
      logic [1:0]                      slp_mode;
      logic [REG_CNT-1:0]              slp_grp_c;
      logic [REG_CNT-1:0]              slp_grp_f;
      logic [REG_CNT-1:0]              rail_en;
      logic [REG_CNT-1:0]              sleep;
      logic [REG_CNT-1:0]              pg_prev;
      rcp_gpo_cfg_t [GPO_CNT-1:0]      gpo;
      logic [EV_W-1:0]                 int_st;
      logic [EV_W-1:0]                 int_msk;
      logic [31:0]                     prdata;
   } rcp_top_st_t;

   typedef struct packed {
      logic [CTL_CNT-1:0] prev;
   } rcp_edge_st_t;

   typedef struct packed {
      logic level;
   } rcp_gout_st_t;
   //--------------------------------------------------
   // Reset values
   //--------------------------------------------------
   localparam rcp_gpo_cfg_t GPO_RST = '{src_reg: 1'b1, val: 1'b1, push_pull: 1'b0, sel: '0};
   localparam rcp_top_st_t  TOP_RST = '{gpo: {GPO_CNT{GPO_RST}}, default: '0};
   localparam rcp_edge_st_t EDGE_RST = '{prev: '0};
   localparam rcp_gout_st_t GOUT_RST = '{level: 1'b1};
endpackage : rcp_pkg

// ---- hw/rcp_top.sv ----
// Purpose: Rail control pin logic with APB registers
// Assumes: All pins and power-good inputs synchronous to pclk
// Notes:   Zero-wait APB slave; unmapped accesses answer with pslverr
`timescale 1ns/10ps
//--------------------------------------------------
//--------------------------------------------------
module rcp_top (
   // APB
   input  wire logic                        pclk,
   input  wire logic                        presetn,
   input  wire logic                        psel,
   input  wire logic                        penable,
   input  wire logic                        pwrite,
   input  wire logic [7:0]                  paddr,
   input  wire logic [31:0]                 pwdata,
   output logic      [31:0]                 prdata,
   output logic                             pready,
   output logic                             pslverr,
   // Rail control pins
   input  wire logic                        rail_ctrl_in_a,
   input  wire logic                        rail_ctrl_in_b,
   input  wire logic                        rail_ctrl_in_c,
   input  wire logic                        rail_ctrl_in_d,
   input  wire logic                        rail_ctrl_in_e,
   input  wire logic                        rail_ctrl_in_f,
   // Regulator side
   input  wire logic [rcp_pkg::REG_CNT-1:0] rail_pg,
   output logic      [rcp_pkg::REG_CNT-1:0] rail_en,
   output logic      [rcp_pkg::REG_CNT-1:0] rail_sleep,
   // Interrupt pin
   output logic                             irq_out_n_o,
   output logic                             irq_out_n_oe_n,
   // General-purpose output pins
   output logic                             gen_out_a_o,
   output logic                             gen_out_a_oe_n,
   output logic                             gen_out_b_o,
   output logic                             gen_out_b_oe_n,
   output logic                             gen_out_c_o,
   output logic                             gen_out_c_oe_n,
   output logic                             gen_out_d_o,
   output logic                             gen_out_d_oe_n
);
   //--------------------------------------------------
   // Helpers
   //--------------------------------------------------
   function automatic logic [7:0] reg_addr(input logic [7:0] base, input int idx);
      reg_addr = base + 8'(idx * 4);
   endfunction : reg_addr

   function automatic logic addr_ok(input logic [7:0] a);
      addr_ok = (a[1:0] == 2'h0) && (a <= rcp_pkg::A_INT_MSK);
   endfunction : addr_ok

   //--------------------------------------------------
   // Declarations
   //--------------------------------------------------
   rcp_pkg::rcp_top_st_t              st_ff;
   rcp_pkg::rcp_top_st_t              nxt_st;
   logic [rcp_pkg::CTL_CNT-1:0]       ctl_lvl;
   logic [rcp_pkg::CTL_CNT-1:0]       ctl_rise;
   logic [rcp_pkg::CTL_CNT-1:0]       ctl_fall;
   logic [rcp_pkg::CTL_CNT-1:0]       ctl_is_en;
   logic [rcp_pkg::REG_CNT-1:0]       on_m;
   logic [rcp_pkg::REG_CNT-1:0]       off_m;
   logic [rcp_pkg::REG_CNT-1:0]       slp_m;
   logic [rcp_pkg::EV_W-1:0]          ev;
   logic [31:0]                       rd_val;
   logic                              sleep_req_n_first;
   logic                              sleep_req_n_second;
   logic                              setup_rd;
   logic                              wr_acc;
   logic                              rd_acc;
   logic [rcp_pkg::GPO_CNT-1:0]       gpo_o;
   logic [rcp_pkg::GPO_CNT-1:0]       gpo_oe_n;

   assign ctl_lvl = {rail_ctrl_in_f, rail_ctrl_in_e, rail_ctrl_in_d,
                     rail_ctrl_in_c, rail_ctrl_in_b, rail_ctrl_in_a};
   assign sleep_req_n_first  = rail_ctrl_in_c;
   assign sleep_req_n_second = rail_ctrl_in_f;

   assign setup_rd = psel && !penable && !pwrite;
   assign wr_acc   = psel && penable && pwrite;
   assign rd_acc   = psel && penable && !pwrite;

   //--------------------------------------------------
   // Pin edges
   //--------------------------------------------------
   rcp_edge_det u_edge (
      .pclk    (pclk),
      .presetn (presetn),
      .lvl     (ctl_lvl),
      .rise    (ctl_rise),
      .fall    (ctl_fall)
   );

   //--------------------------------------------------
   // Next state
   //--------------------------------------------------
   always_comb begin
      nxt_st    = st_ff;
      ctl_is_en = '1;
      ctl_is_en[rcp_pkg::IDX_C] = !st_ff.slp_mode[rcp_pkg::F_SLP_C];
      ctl_is_en[rcp_pkg::IDX_F] = !st_ff.slp_mode[rcp_pkg::F_SLP_F];
      on_m  = '0;
      off_m = '0;
      for (int i = 0; i < rcp_pkg::CTL_CNT; i++) begin
         if (ctl_is_en[i] && ctl_rise[i]) begin
            on_m = on_m | st_ff.grp[i];
         end
         if (ctl_is_en[i] && ctl_fall[i]) begin
            off_m = off_m | st_ff.grp[i];
         end
      end
      // Switching off wins over switching on for a shared rail
      nxt_st.rail_en = (st_ff.rail_en | on_m) & ~off_m;

      slp_m = '0;
      if (st_ff.slp_mode[rcp_pkg::F_SLP_C] && !sleep_req_n_first) begin
         slp_m = slp_m | st_ff.slp_grp_c;
      end
      if (st_ff.slp_mode[rcp_pkg::F_SLP_F] && !sleep_req_n_second) begin
         slp_m = slp_m | st_ff.slp_grp_f;
      end
      nxt_st.sleep   = slp_m;
      nxt_st.pg_prev = rail_pg;

      ev = {|(st_ff.pg_prev & ~rail_pg & st_ff.rail_en), ctl_rise | ctl_fall};

      // Read value, captured in the setup phase
      rd_val = '0;
      for (int i = 0; i < rcp_pkg::CTL_CNT; i++) begin
         if (paddr == reg_addr(rcp_pkg::A_GRP_BASE, i)) begin
            rd_val[rcp_pkg::REG_CNT-1:0] = st_ff.grp[i];
         end
      end
      for (int i = 0; i < rcp_pkg::GPO_CNT; i++) begin
         if (paddr == reg_addr(rcp_pkg::A_GPO_BASE, i)) begin
            rd_val[rcp_pkg::REG_CNT-1:0]  = st_ff.gpo[i].sel;
            rd_val[rcp_pkg::F_GPO_SRC]    = st_ff.gpo[i].src_reg;
            rd_val[rcp_pkg::F_GPO_VAL]    = st_ff.gpo[i].val;
            rd_val[rcp_pkg::F_GPO_PP]     = st_ff.gpo[i].push_pull;
         end
      end
      unique case (paddr)
         rcp_pkg::A_SLP_MODE:  rd_val[1:0] = st_ff.slp_mode;
         rcp_pkg::A_SLP_GRP_C: rd_val[rcp_pkg::REG_CNT-1:0] = st_ff.slp_grp_c;
         rcp_pkg::A_SLP_GRP_F: rd_val[rcp_pkg::REG_CNT-1:0] = st_ff.slp_grp_f;
         rcp_pkg::A_RAIL_ST:   rd_val[rcp_pkg::REG_CNT-1:0] = st_ff.rail_en;
         rcp_pkg::A_SLP_ST:    rd_val[rcp_pkg::REG_CNT-1:0] = st_ff.sleep;
         rcp_pkg::A_INT_ST:    rd_val[rcp_pkg::EV_W-1:0] = st_ff.int_st;
         rcp_pkg::A_INT_MSK:   rd_val[rcp_pkg::EV_W-1:0] = st_ff.int_msk;
         default:              rd_val = rd_val;
      endcase
      if (setup_rd) begin
         nxt_st.prdata = rd_val;
      end

      // Only the bits returned are cleared, and a new event wins
      nxt_st.int_st = st_ff.int_st | ev;
      if (rd_acc && paddr == rcp_pkg::A_INT_ST) begin
         nxt_st.int_st = (st_ff.int_st & ~st_ff.prdata[rcp_pkg::EV_W-1:0]) | ev;
      end

      if (wr_acc) begin
         for (int i = 0; i < rcp_pkg::CTL_CNT; i++) begin
            if (paddr == reg_addr(rcp_pkg::A_GRP_BASE, i)) begin
               nxt_st.grp[i] = pwdata[rcp_pkg::REG_CNT-1:0];
            end
         end
         for (int i = 0; i < rcp_pkg::GPO_CNT; i++) begin
            if (paddr == reg_addr(rcp_pkg::A_GPO_BASE, i)) begin
               nxt_st.gpo[i].sel       = pwdata[rcp_pkg::REG_CNT-1:0];
               nxt_st.gpo[i].src_reg   = pwdata[rcp_pkg::F_GPO_SRC];
               nxt_st.gpo[i].val       = pwdata[rcp_pkg::F_GPO_VAL];
               nxt_st.gpo[i].push_pull = (i < rcp_pkg::GPO_PP_CNT) && pwdata[rcp_pkg::F_GPO_PP];
            end
         end
         unique case (paddr)
            rcp_pkg::A_SLP_MODE:  nxt_st.slp_mode  = pwdata[1:0];
            rcp_pkg::A_SLP_GRP_C: nxt_st.slp_grp_c = pwdata[rcp_pkg::REG_CNT-1:0];
            rcp_pkg::A_SLP_GRP_F: nxt_st.slp_grp_f = pwdata[rcp_pkg::REG_CNT-1:0];
            rcp_pkg::A_INT_MSK:   nxt_st.int_msk   = pwdata[rcp_pkg::EV_W-1:0];
            default:              nxt_st.int_msk   = nxt_st.int_msk;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_ff <= rcp_pkg::TOP_RST;
      end else begin
         st_ff <= nxt_st;
      end
   end

   //--------------------------------------------------
   // Outputs
   //--------------------------------------------------
   assign prdata     = st_ff.prdata;
   assign pready     = 1'b1;
   assign pslverr    = psel && penable && !addr_ok(paddr);
   assign rail_en    = st_ff.rail_en;
   assign rail_sleep = st_ff.sleep;

   assign irq_out_n_o    = 1'b0;
   assign irq_out_n_oe_n = ~|(st_ff.int_st & st_ff.int_msk);

   for (genvar g = 0; g < rcp_pkg::GPO_CNT; g++) begin : g_gpo
      rcp_gen_out #(
         .OD_ONLY (g == rcp_pkg::GPO_CNT - 1)
      ) u_gout (
         .pclk     (pclk),
         .presetn  (presetn),
         .cfg      (st_ff.gpo[g]),
         .pg       (rail_pg),
         .pin_o    (gpo_o[g]),
         .pin_oe_n (gpo_oe_n[g])
      );
   end

   assign gen_out_a_o    = gpo_o[0];
   assign gen_out_a_oe_n = gpo_oe_n[0];
   assign gen_out_b_o    = gpo_o[1];
   assign gen_out_b_oe_n = gpo_oe_n[1];
   assign gen_out_c_o    = gpo_o[2];
   assign gen_out_c_oe_n = gpo_oe_n[2];
   assign gen_out_d_o    = gpo_o[3];
   assign gen_out_d_oe_n = gpo_oe_n[3];

   //--------------------------------------------------
   // Assertions
   //--------------------------------------------------
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   property p_pin_a_on;
      rail_ctrl_in_a && !$past(rail_ctrl_in_a) && ctl_fall == '0
      |=> (st_ff.rail_en & $past(st_ff.grp[0])) == $past(st_ff.grp[0]);
   endproperty
   a_pin_a_on: assert property (p_pin_a_on) else $error("rise did not enable group");

   property p_pin_b_off;
      ctl_fall[1] |=> (st_ff.rail_en & $past(st_ff.grp[1])) == '0;
   endproperty
   a_pin_b_off: assert property (p_pin_b_off) else $error("fall did not disable group");

   property p_sleep_pin_no_en;
      st_ff.slp_mode[rcp_pkg::F_SLP_C] && ctl_rise == 6'h04 && ctl_fall == '0
      |=> st_ff.rail_en == $past(st_ff.rail_en);
   endproperty
   a_sleep_pin_no_en: assert property (p_sleep_pin_no_en) else $error("sleep pin changed enables");

   property p_sleep_enter;
      st_ff.slp_mode == 2'h1 && !rail_ctrl_in_c |=> rail_sleep == $past(st_ff.slp_grp_c);
   endproperty
   a_sleep_enter: assert property (p_sleep_enter) else $error("sleep group wrong");

   property p_irq_pull;
      (ev & st_ff.int_msk) != '0 |=> !irq_out_n_oe_n && !irq_out_n_o;
   endproperty
   a_irq_pull: assert property (p_irq_pull) else $error("interrupt not asserted");

   property p_gpo_b_pp;
      st_ff.gpo[1].src_reg && st_ff.gpo[1].push_pull ##1 $stable(st_ff.gpo[1])
      |-> !gen_out_b_oe_n && gen_out_b_o == $past(st_ff.gpo[1].val);
   endproperty
   a_gpo_b_pp: assert property (p_gpo_b_pp) else $error("push-pull output wrong");

   property p_gpo_d_od;
      st_ff.gpo[3].src_reg ##1 st_ff.gpo[3].src_reg
      |-> !gen_out_d_o && gen_out_d_oe_n == $past(st_ff.gpo[3].val);
   endproperty
   a_gpo_d_od: assert property (p_gpo_d_od) else $error("output d not open-drain");

   property p_gpo_c_pg;
      !st_ff.gpo[2].src_reg && st_ff.gpo[2].sel != '0 ##1 $stable(st_ff.gpo[2])
      |-> (st_ff.gpo[2].push_pull ? gen_out_c_o : gen_out_c_oe_n)
          == ($past((rail_pg & st_ff.gpo[2].sel)) == $past(st_ff.gpo[2].sel));
   endproperty
   a_gpo_c_pg: assert property (p_gpo_c_pg) else $error("power good combine wrong");

   property p_sleep_f_enter;
      st_ff.slp_mode[rcp_pkg::F_SLP_F] && !rail_ctrl_in_f
      |=> (rail_sleep & $past(st_ff.slp_grp_f)) == $past(st_ff.slp_grp_f);
   endproperty
   a_sleep_f_enter: assert property (p_sleep_f_enter) else $error("sleep group f not asleep");

   property p_gpo_a_od;
      !st_ff.gpo[0].push_pull |-> !gen_out_a_o;
   endproperty
   a_gpo_a_od: assert property (p_gpo_a_od) else $error("open-drain output a drove high");
endmodule : rcp_top

// ---- tb/rcp_host_model.sv ----
// Purpose: Host-side model driving the six rail control pins
// Assumes: Requests change right after a pclk edge
// Notes:   Pins are registered, so they move only on a clock edge
`timescale 1ns/10ps
module rcp_host_model (
   // Clock and reset
   input  wire logic       pclk,
   input  wire logic       presetn,
   // Requested and driven levels
   input  wire logic [5:0] pin_req,
   output logic      [5:0] pins
);
   logic [5:0] pins_ff;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pins_ff <= 6'h00;
      end else begin
         pins_ff <= pin_req;
      end
   end
   assign pins = pins_ff;
endmodule : rcp_host_model

// ---- tb/testbench.sv ----
// Purpose: Self-checking bench of the rail control pin logic
// Assumes: Zero-wait APB slave, pins sampled on pclk
// Notes:   Expected results queue up; two monitors compare in order
`timescale 1ns/10ps
module testbench;
   typedef struct {
      int          sel;
      logic [32:0] val;
   } rcp_exp_t;
   //--------------------------------------------------
   // Signals
   //--------------------------------------------------
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [7:0]  paddr, rail_pg, rail_en, rail_sleep, sc, sf, m;
   logic [31:0] pwdata, prdata;
   logic [5:0]  pin_req, pins;
   logic        irq_o, irq_oe_n;
   logic [3:0]  go_o, go_oe_n;
   logic [7:0]  grp [6];
   int          err_count, checked, cyc;
   rcp_exp_t    exp_q [$];
   event        look;

   always #10 pclk = ~pclk;

   rcp_host_model u_rcp_host_model (.pclk(pclk), .presetn(presetn), .pin_req(pin_req), .pins(pins));

   rcp_top u_rcp_top (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .rail_ctrl_in_a(pins[0]), .rail_ctrl_in_b(pins[1]), .rail_ctrl_in_c(pins[2]),
      .rail_ctrl_in_d(pins[3]), .rail_ctrl_in_e(pins[4]), .rail_ctrl_in_f(pins[5]),
      .rail_pg(rail_pg), .rail_en(rail_en), .rail_sleep(rail_sleep),
      .irq_out_n_o(irq_o), .irq_out_n_oe_n(irq_oe_n),
      .gen_out_a_o(go_o[0]), .gen_out_a_oe_n(go_oe_n[0]), .gen_out_b_o(go_o[1]), .gen_out_b_oe_n(go_oe_n[1]),
      .gen_out_c_o(go_o[2]), .gen_out_c_oe_n(go_oe_n[2]), .gen_out_d_o(go_o[3]), .gen_out_d_oe_n(go_oe_n[3])
   );
   //--------------------------------------------------
   // Checking
   //--------------------------------------------------
   function automatic logic [32:0] obs(input int s);
      case (s)
         1: obs = {25'h0, rail_en};
         2: obs = {25'h0, rail_sleep};
         3: obs = {31'h0, irq_oe_n, irq_o};
         default: obs = {31'h0, go_oe_n[s-10], go_o[s-10]};
      endcase
   endfunction : obs

   task automatic cmp(input logic [32:0] exp_v, input logic [32:0] got);
      checked++;
      if (got !== exp_v) begin
         err_count++;
         $display("[FAIL] %0t mismatch exp %h got %h", $time, exp_v, got);
      end
   endtask : cmp

   task automatic conclude();
      $display("checks %0d errors %0d", checked, err_count);
      if (err_count == 0 && checked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : conclude

   // Pin notes are compared just after the edge; bus notes stay for the bus monitor
   always begin : pin_mon
      rcp_exp_t e;
      @(look);
      #1;
      while (exp_q.size() > 0 && exp_q[0].sel != 0) begin
         e = exp_q.pop_front();
         cmp(e.val, obs(e.sel));
      end
   end

   always @(posedge pclk) begin : apb_mon
      rcp_exp_t e;
      if (psel && penable && pready) begin
         e = exp_q.pop_front();
         cmp(e.val, pwrite ? {pslverr, 32'h0} : {pslverr, prdata});
      end
   end

   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         err_count++;
         conclude();
      end
   end
   //--------------------------------------------------
   // Drivers
   //--------------------------------------------------
   task automatic step(input int n);
      repeat (n) @(posedge pclk);
   endtask : step

   task automatic chk(input int s, input logic [32:0] v);
      exp_q.push_back('{s, v});
      -> look;
   endtask : chk

   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [32:0] e);
      exp_q.push_back('{0, e});
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d, 33'h0);
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [31:0] d);
      apb(1'b0, a, 32'h0, {1'b0, d});
   endtask : rd
   //--------------------------------------------------
   // Scenarios
   //--------------------------------------------------
   initial begin : main
      int          i;
      logic [7:0]  a;
      logic [32:0] hi;
      pclk = 1'b0; presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
      paddr = 8'h00; pwdata = 32'h0; pin_req = 6'h00; rail_pg = 8'hFF; cyc = 0;
      void'($urandom(75410));
      step(12);
      presetn <= 1'b1;
      step(2);
      chk(3, 33'h2);
      rd(rcp_pkg::A_INT_ST, 32'h0);
      for (i = 0; i < 6; i++) begin
         grp[i] = 8'($urandom()) | 8'h01;
         wr(rcp_pkg::A_GRP_BASE + 8'(4*i), {24'h0, grp[i]});
      end
      for (i = 0; i < 6; i++) begin
         pin_req[i] <= 1'b1;
         step(3);
         chk(1, {25'h0, grp[i]});
         rd(rcp_pkg::A_RAIL_ST, {24'h0, grp[i]});
         pin_req[i] <= 1'b0;
         step(3);
         chk(1, 33'h0);
         chk(3, 33'h2);
         rd(rcp_pkg::A_INT_ST, 32'h1 << i);
      end
      wr(rcp_pkg::A_INT_MSK, 32'h0000007F);
      pin_req[1] <= 1'b1;
      step(3);
      chk(3, 33'h0);
      rd(rcp_pkg::A_INT_ST, 32'h2);
      step(1);
      chk(3, 33'h2);
      rail_pg <= 8'hFE;
      step(3);
      rd(rcp_pkg::A_INT_ST, 32'h40);
      rail_pg <= 8'hFF;
      pin_req[1] <= 1'b0;
      step(3);
      rd(rcp_pkg::A_INT_ST, 32'h2);
      sc = 8'($urandom());
      sf = 8'($urandom());
      wr(rcp_pkg::A_SLP_GRP_C, {24'h0, sc});
      wr(rcp_pkg::A_SLP_GRP_F, {24'h0, sf});
      wr(rcp_pkg::A_SLP_MODE, 32'h3);
      step(3);
      chk(2, {25'h0, sc | sf});
      pin_req[rcp_pkg::IDX_C] <= 1'b1;
      step(3);
      chk(2, {25'h0, sf});
      chk(1, 33'h0);
      pin_req[rcp_pkg::IDX_F] <= 1'b1;
      step(3);
      rd(rcp_pkg::A_SLP_ST, 32'h0);
      pin_req[rcp_pkg::IDX_C] <= 1'b0;
      step(3);
      chk(2, {25'h0, sc});
      pin_req[rcp_pkg::IDX_F] <= 1'b0;
      wr(rcp_pkg::A_SLP_MODE, 32'h1);
      step(3);
      chk(2, {25'h0, sc});
      wr(rcp_pkg::A_SLP_MODE, 32'h0);
      rd(rcp_pkg::A_INT_ST, 32'h24);
      for (i = 0; i < 4; i++) begin
         a  = rcp_pkg::A_GPO_BASE + 8'(4*i);
         hi = (i < 3) ? 33'h1 : 33'h2;
         m  = 8'($urandom()) | 8'h01;
         chk(10 + i, 33'h2);
         rd(a, 32'h00030000);
         wr(a, 32'h00010000);
         step(3);
         chk(10 + i, 33'h0);
         wr(a, 32'h00070000);
         step(3);
         chk(10 + i, hi);
         rd(a, (i < 3) ? 32'h00070000 : 32'h00030000);
         wr(a, 32'h00040000 | {24'h0, m});
         step(3);
         chk(10 + i, hi);
         rail_pg <= 8'hFE;
         step(3);
         chk(10 + i, 33'h0);
         rail_pg <= m;
         step(3);
         chk(10 + i, hi);
         rail_pg <= 8'hFF;
      end
      apb(1'b1, rcp_pkg::A_RAIL_ST, 32'hFFFFFFFF, 33'h0);
      rd(rcp_pkg::A_RAIL_ST, 32'h0);
      apb(1'b1, 8'h46, 32'h1, {1'b1, 32'h0});
      apb(1'b0, 8'h44, 32'h0, {1'b1, 32'h0});
      step(2);
      conclude();
   end
endmodule : testbench
